// [rtl/txdma_chain.sv]
// chained transmit dma channel: descriptor walk, buffer reads, transmitter feed
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module txdma_chain
   import txdma_pkg::*;
(
   input wire logic clock, // system clock, 20 MHz
   input wire logic rstn, // synchronous reset, active low
   input wire logic [2:0] reg_addr, // register index
   input wire logic [15:0] reg_wdata, // register write data
   input wire logic reg_wr, // register write strobe
   input wire logic reg_rd, // register read strobe
   output logic [15:0] reg_rdata, // read data, cycle after strobe
   output logic bus_req, // asks arbiter for the memory bus
   input wire logic bus_grant, // arbiter grant
   output logic [23:0] mem_addr, // memory read address
   output logic mem_rd, // memory read pulse
   output logic mem_byte, // read is a single byte
   input wire logic [15:0] mem_rdata, // memory read data
   input wire logic mem_ack, // read data valid pulse
   input wire logic tx_req, // transmitter wants data, level
   output logic tx_wr, // data pulse to transmitter
   output logic [15:0] tx_data, // data to transmitter
   output logic tx_word, // both bytes of tx_data valid
   output logic tx_frame_end, // last data of a frame
   output logic frame_done_irq, // frame or transfer done pulse
   output logic halt_error_irq // halt pointer or overflow pulse
);
   ////////////////////////////////////////////////////////////////
   state_t state, next_state;
   logic [7:0] chain_base;
   logic [15:0] halt_ptr, cur_ptr, bytes_remaining;
   logic [23:0] bar;
   logic [CFG_BITS-1:0] cfg;
   logic enable;
   logic [15:0] cp_field, dl_field;
   logic [23:0] bp_field;
   logic [7:0] flag_byte;
   logic [2:0] fidx;
   logic rd_pend, cur_word;
   logic use_word;
   logic [15:0] step, pend_step;
   logic [3:0] pending_frame_count;
   logic fct_full;

   function automatic logic reg_hit(input logic [2:0] a, input logic [2:0] code);
      reg_hit = (a == code);
   endfunction

   wire logic wr_status = reg_wr && reg_hit(reg_addr, REG_STATUS);
   wire logic multi = cfg[CFG_MULTI];
   wire logic frame_end_flag = flag_byte[FLAG_FRAME_END];
   wire logic chain_end_flag = flag_byte[FLAG_CHAIN_END];
   // request checked against the halt pointer only in the check state
   wire logic halt_hit = state == S_CHECK && enable && tx_req && cur_ptr == halt_ptr;
   wire logic start_fetch = state == S_CHECK && enable && tx_req && cur_ptr != halt_ptr;
   wire logic fetch_ack = state == S_FETCH && rd_pend && mem_ack;
   wire logic fetch_done = fetch_ack && fidx == DESC_FLAGS;
   wire logic data_ack = state == S_DATA && rd_pend && mem_ack;
   wire logic issue_rd = !rd_pend && (state == S_FETCH || (state == S_DATA && tx_req && bytes_remaining != COUNT_ZERO));
   wire logic in_switch = state == S_SWITCH;
   wire logic stop_ovf = in_switch && multi && frame_end_flag && !chain_end_flag && fct_full;
   wire logic stop = in_switch && ((!multi && frame_end_flag) || chain_end_flag || stop_ovf);

   txdma_step u_step (
      .word_bus(cfg[CFG_WORD_BUS]),
      .addr0(bar[0]),
      .count(bytes_remaining),
      .use_word(use_word),
      .step(step)
   );

   txdma_frame_count u_fct (
      .clock(clock),
      .rstn(rstn),
      .inc(in_switch && multi && frame_end_flag && !stop_ovf),
      .dec(wr_status && reg_wdata[ST_FRAME_ACK_BIT]),
      .clear(stop_ovf),
      .count(pending_frame_count),
      .full(fct_full)
   );

   ////////////////////////////////////////////////////////////////
   always_comb begin
      next_state = state;
      case (state)
         S_IDLE: if (enable && cfg[CFG_CHAIN_KIND]) next_state = S_ARB;
         S_ARB: begin
            if (!enable) next_state = S_IDLE;
            else if (bus_grant) next_state = S_CHECK;
         end
         S_CHECK: begin
            if (!enable || halt_hit) next_state = S_IDLE;
            else if (start_fetch) next_state = S_FETCH;
         end
         S_FETCH: if (fetch_done) next_state = S_DATA;
         S_DATA: if (bytes_remaining == COUNT_ZERO && !rd_pend) next_state = S_SWITCH;
         S_SWITCH: next_state = stop ? S_IDLE : S_CHECK;
         default: next_state = S_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         state <= S_IDLE;
         bus_req <= 1'b0;
      end else begin
         state <= next_state;
         bus_req <= next_state != S_IDLE;
      end
   end

   ////////////////////////////////////////////////////////////////
   // software set wins over the hardware clear in the same cycle
   always_ff @(posedge clock) begin
      if (!rstn) begin
         enable <= 1'b0;
      end else if (wr_status) begin
         enable <= reg_wdata[ST_ENABLE_BIT];
      end else if (stop || halt_hit) begin
         enable <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         chain_base <= 8'h00;
         halt_ptr <= 16'h0000;
         cfg <= CFG_RESET;
      end else if (reg_wr) begin
         // base frozen while the channel runs
         if (reg_hit(reg_addr, REG_CHAIN_BASE) && state == S_IDLE) chain_base <= reg_wdata[7:0];
         if (reg_hit(reg_addr, REG_HALT_PTR)) halt_ptr <= reg_wdata;
         if (reg_hit(reg_addr, REG_CONFIG)) cfg <= reg_wdata[CFG_BITS-1:0];
      end
   end

   // kept across a stop so the next enable picks up the next frame
   always_ff @(posedge clock) begin
      if (!rstn) begin
         cur_ptr <= 16'h0000;
      end else if (in_switch) begin
         cur_ptr <= cp_field;
      end else if (reg_wr && reg_hit(reg_addr, REG_CUR_PTR) && state == S_IDLE) begin
         cur_ptr <= reg_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////
   always_ff @(posedge clock) begin
      if (!rstn) begin
         cp_field <= 16'h0000;
         bp_field <= 24'h000000;
         dl_field <= 16'h0000;
         flag_byte <= 8'h00;
      end else if (fetch_ack) begin
         case (fidx)
            DESC_CP: cp_field <= mem_rdata;
            DESC_BP_LO: bp_field[15:0] <= mem_rdata;
            DESC_BP_HI: bp_field[23:16] <= mem_rdata[7:0];
            DESC_LEN: dl_field <= mem_rdata;
            default: flag_byte <= mem_rdata[7:0];
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn || start_fetch) begin
         fidx <= DESC_CP;
      end else if (fetch_ack) begin
         fidx <= fidx + 3'h1;
      end
   end

   // only the channel moves the read address and count
   always_ff @(posedge clock) begin
      if (!rstn) begin
         bar <= 24'h000000;
         bytes_remaining <= COUNT_ZERO;
      end else if (fetch_done) begin
         bar <= bp_field;
         bytes_remaining <= dl_field;
      end else if (data_ack) begin
         bar <= bar + {8'h00, pend_step};
         bytes_remaining <= bytes_remaining - pend_step;
      end
   end

   ////////////////////////////////////////////////////////////////
   always_ff @(posedge clock) begin
      if (!rstn) begin
         rd_pend <= 1'b0;
         cur_word <= 1'b0;
         pend_step <= STEP_BYTE;
         mem_rd <= 1'b0;
         mem_byte <= 1'b0;
         mem_addr <= 24'h000000;
      end else begin
         mem_rd <= issue_rd;
         if (issue_rd) begin
            rd_pend <= 1'b1;
            if (state == S_FETCH) begin
               mem_addr <= {chain_base, cur_ptr + {12'h000, fidx, 1'b0}};
               mem_byte <= 1'b0;
               cur_word <= 1'b1;
            end else begin
               mem_addr <= bar;
               mem_byte <= !use_word;
               cur_word <= use_word;
               pend_step <= step;
            end
         end else if (mem_ack) begin
            rd_pend <= 1'b0;
         end
      end
   end

   // byte lane follows the address, low byte at even addresses
   always_ff @(posedge clock) begin
      if (!rstn) begin
         tx_wr <= 1'b0;
         tx_data <= 16'h0000;
         tx_word <= 1'b0;
         tx_frame_end <= 1'b0;
      end else begin
         tx_wr <= data_ack;
         if (data_ack) begin
            tx_data <= cur_word ? mem_rdata : {8'h00, (bar[0] ? mem_rdata[15:8] : mem_rdata[7:0])};
            tx_word <= cur_word;
            tx_frame_end <= frame_end_flag && (bytes_remaining == pend_step);
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         frame_done_irq <= 1'b0;
         halt_error_irq <= 1'b0;
      end else begin
         frame_done_irq <= cfg[CFG_FRAME_IRQ_EN] && in_switch && (frame_end_flag || chain_end_flag);
         halt_error_irq <= cfg[CFG_HALT_IRQ_EN] && (halt_hit || stop_ovf);
      end
   end

   ////////////////////////////////////////////////////////////////
   always_ff @(posedge clock) begin
      if (!rstn || !reg_rd) begin
         reg_rdata <= RD_ZERO;
      end else begin
         case (reg_addr)
            REG_CHAIN_BASE: reg_rdata <= {8'h00, chain_base};
            REG_HALT_PTR: reg_rdata <= halt_ptr;
            REG_CUR_PTR: reg_rdata <= cur_ptr;
            REG_REMAIN: reg_rdata <= bytes_remaining;
            REG_BUF_LO: reg_rdata <= bar[15:0];
            REG_BUF_HI: reg_rdata <= {8'h00, bar[23:16]};
            REG_CONFIG: reg_rdata <= {11'h000, cfg};
            default: reg_rdata <= {8'h00, pending_frame_count, 2'b00, enable, state != S_IDLE};
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   sequence seq_frame_switch;
      state == S_SWITCH && frame_end_flag;
   endsequence
   sequence seq_halt_req;
      state == S_CHECK && enable && tx_req && cur_ptr == halt_ptr;
   endsequence

   chk_grant_before_check: assert property (
      (state == S_CHECK && $past(state) == S_ARB) |-> $past(bus_grant)) else $error("check entered without grant");
   chk_desc_first_read: assert property (
      (mem_rd && $past(state) == S_FETCH && fidx == DESC_CP) |-> mem_addr == {chain_base, cur_ptr})
      else $error("descriptor read at wrong address");
   chk_counter_load: assert property (
      ($past(state) == S_FETCH && state == S_DATA) |-> bytes_remaining == dl_field && bar == bp_field)
      else $error("counters not loaded from descriptor");
   chk_count_step: assert property (
      data_ack |=> bytes_remaining == $past(bytes_remaining) - $past(pend_step) && bar == $past(bar) + {8'h00, $past(pend_step)})
      else $error("count or address stepped wrongly");
   chk_pointer_advance: assert property (
      state == S_SWITCH |=> cur_ptr == $past(cp_field)) else $error("pointer not advanced");
   chk_single_stop: assert property (
      (seq_frame_switch and (!multi && !wr_status)) |=> state == S_IDLE && !enable)
      else $error("single frame did not stop");
   chk_frame_irq: assert property (
      seq_frame_switch |=> frame_done_irq == $past(cfg[CFG_FRAME_IRQ_EN])) else $error("frame irq wrong");
   chk_halt_stop: assert property (
      seq_halt_req |=> state == S_IDLE && halt_error_irq == $past(cfg[CFG_HALT_IRQ_EN]) ##1 !mem_rd)
      else $error("halt match did not stop");
   chk_fct_overflow: assert property (
      stop_ovf |=> pending_frame_count == FCT_ZERO && state == S_IDLE) else $error("overflow not handled");
   chk_odd_byte: assert property (
      (mem_rd && $past(state) == S_DATA && mem_addr[0]) |-> mem_byte) else $error("odd address read as word");
   chk_frame_end_mark: assert property (
      (tx_wr && tx_frame_end) |-> frame_end_flag && bytes_remaining == COUNT_ZERO) else $error("frame end marked early");
   chk_chain_end_stop: assert property (
      (state == S_SWITCH && chain_end_flag && !wr_status) |=> state == S_IDLE && !enable)
      else $error("chain end did not stop");
endmodule

// [rtl/txdma_pkg.sv]
// constants and types for the chained transmit dma channel
//
// Operation
// - transmit channel moves data on transmitter requests
// - base high byte fixed while channel runs
// - no transfer before bus grant arrives
// - descriptor fetched before any buffer data read
// - buffer start and length loaded into counters
// - address up, count down by one or two
// - zero count switches to next descriptor
// - single-frame mode stops after frame end buffer
// - enable auto-clears; setting it again resumes
// - pointers kept across stop for next frame
// - chain end flag completes multi-frame transfer
// - frame or transfer completion raises frame interrupt
// - halt pointer writable while channel enabled
// - current equals halt on request: stop, error
// - enable flag sits at status bit one
// - frame counter overflow stops, clears, flags error
// - odd start on word bus sends byte first
package txdma_pkg;
   localparam logic [2:0] REG_CHAIN_BASE = 3'h0;
   localparam logic [2:0] REG_HALT_PTR = 3'h1;
   localparam logic [2:0] REG_CUR_PTR = 3'h2;
   localparam logic [2:0] REG_REMAIN = 3'h3;
   localparam logic [2:0] REG_BUF_LO = 3'h4;
   localparam logic [2:0] REG_BUF_HI = 3'h5;
   localparam logic [2:0] REG_CONFIG = 3'h6;
   localparam logic [2:0] REG_STATUS = 3'h7;
   localparam int CFG_CHAIN_KIND = 0;
   localparam int CFG_MULTI = 1;
   localparam int CFG_WORD_BUS = 2;
   localparam int CFG_FRAME_IRQ_EN = 3;
   localparam int CFG_HALT_IRQ_EN = 4;
   localparam int CFG_BITS = 5;
   localparam logic [4:0] CFG_RESET = 5'h00;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_ENABLE_BIT = 1;
   localparam int ST_FRAME_ACK_BIT = 2;
   localparam logic [2:0] DESC_CP = 3'h0;
   localparam logic [2:0] DESC_BP_LO = 3'h1;
   localparam logic [2:0] DESC_BP_HI = 3'h2;
   localparam logic [2:0] DESC_LEN = 3'h3;
   localparam logic [2:0] DESC_FLAGS = 3'h4;
   localparam int FLAG_FRAME_END = 7;
   localparam int FLAG_CHAIN_END = 6;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
   localparam logic [15:0] STEP_BYTE = 16'h0001;
   localparam logic [15:0] STEP_WORD = 16'h0002;
   localparam logic [3:0] FCT_FULL = 4'hf;
   localparam logic [3:0] FCT_ZERO = 4'h0;
   localparam logic [15:0] RD_ZERO = 16'h0000;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_ARB = 3'b001,
      S_CHECK = 3'b010,
      S_FETCH = 3'b011,
      S_DATA = 3'b100,
      S_SWITCH = 3'b101
   } state_t;
endpackage

// [rtl/txdma_step.sv]
// byte or word choice for the next buffer read
`timescale 1ns/1ps
module txdma_step
   import txdma_pkg::*;
(
   input wire logic word_bus, // 16-bit memory bus in use
   input wire logic addr0, // low bit of read address
   input wire logic [15:0] count, // bytes left in buffer
   output logic use_word, // next read is a word
   output logic [15:0] step // bytes consumed by next read
);
   // odd address or single byte left forces a byte read
   assign use_word = word_bus && !addr0 && (count > STEP_BYTE);
   assign step = use_word ? STEP_WORD : STEP_BYTE;
endmodule

// [rtl/txdma_frame_count.sv]
// pending frame counter for multi-frame mode
`timescale 1ns/1ps
module txdma_frame_count
   import txdma_pkg::*;
(
   input wire logic clock, // system clock
   input wire logic rstn, // synchronous reset, active low
   input wire logic inc, // a frame completed
   input wire logic dec, // software serviced one frame
   input wire logic clear, // overflow handled
   output logic [3:0] count, // frames not yet serviced
   output logic full // counter at its top value
);
   always_ff @(posedge clock) begin
      if (!rstn || clear) begin
         count <= FCT_ZERO;
      end else if (inc && !dec && count != FCT_FULL) begin
         count <= count + 4'h1;
      end else if (dec && !inc && count != FCT_ZERO) begin
         count <= count - 4'h1;
      end
   end
   assign full = (count == FCT_FULL);
endmodule

// [verif/txdma_mem_model.sv]
// system memory model answering the channel's single-outstanding reads
`timescale 1ns/1ps
module txdma_mem_model (
   input wire logic clock, // system clock
   input wire logic rstn, // synchronous reset, active low
   input wire logic mem_rd, // read request pulse
   input wire logic [23:0] mem_addr, // read address
   input wire logic mem_byte, // single byte read
   input wire logic slow, // answer after three cycles
   output logic [15:0] mem_rdata, // read data
   output logic mem_ack // read data valid pulse
);
   logic [7:0] mem [logic [23:0]];
   logic busy = 1'b0;
   logic bt;
   logic [23:0] a;
   int wait_cnt;
   function automatic logic [7:0] byte_at(input logic [23:0] x);
      return mem.exists(x) ? mem[x] : (x[7:0] ^ 8'h5a);
   endfunction
   ////////////////////////////////////////////////////////////////
   // data lines never hold the last value outside an answer or reset
   always @(posedge clock) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (!rstn) begin
         busy <= 1'b0;
         mem_rdata <= 16'h0000;
      end else if (mem_rd) begin
         busy <= 1'b1;
         a <= mem_addr;
         bt <= mem_byte;
         wait_cnt <= slow ? 3 : 1;
      end else if (busy) begin
         if (wait_cnt <= 1) begin
            busy <= 1'b0;
            mem_ack <= 1'b1;
            mem_rdata <= bt ? {2{byte_at(a)}} : {byte_at(a + 24'h1), byte_at(a)};
         end else begin
            wait_cnt <= wait_cnt - 1;
         end
      end
   end
endmodule

// [verif/tb_txdma_chain.sv]
// testbench for the chained transmit dma channel
`timescale 1ns/1ps
module tb_txdma_chain;
   import txdma_pkg::*;
   logic clock = 0, rstn = 0, reg_wr = 0, reg_rd = 0, bus_grant = 0, tx_req = 0, slow = 0;
   logic [2:0] reg_addr = 3'h0;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, mem_rdata, tx_data, rv;
   logic bus_req, mem_rd, mem_byte, mem_ack, tx_wr, tx_word, tx_frame_end, frame_done_irq, halt_error_irq;
   logic [23:0] mem_addr, first_addr;
   logic [17:0] got_q[$], exp_q[$];
   int mismatches = 0, checked = 0, n_mrd = 0, n_fd = 0, n_he = 0, req_mode = 0, cyc = 0, m0, f0, h0;
   always #25 clock = ~clock;
   txdma_chain u_txdma_chain (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_req(bus_req), .bus_grant(bus_grant),
      .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_byte(mem_byte), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
      .tx_req(tx_req), .tx_wr(tx_wr), .tx_data(tx_data), .tx_word(tx_word), .tx_frame_end(tx_frame_end),
      .frame_done_irq(frame_done_irq), .halt_error_irq(halt_error_irq));
   txdma_mem_model u_txdma_mem_model (.clock(clock), .rstn(rstn), .mem_rd(mem_rd), .mem_addr(mem_addr),
      .mem_byte(mem_byte), .slow(slow), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
   ////////////////////////////////////////////////////////////////
   // transmitter request pattern and traffic monitor
   always @(posedge clock) begin
      cyc <= cyc + 1;
      tx_req <= (req_mode == 1) || (req_mode == 2 && cyc[2]);
      if (mem_rd === 1'b1) begin
         if (n_mrd == 0) first_addr <= mem_addr;
         n_mrd <= n_mrd + 1;
      end
      if (tx_wr === 1'b1) got_q.push_back({tx_frame_end, tx_word, tx_data});
      if (frame_done_irq === 1'b1) n_fd <= n_fd + 1;
      if (halt_error_irq === 1'b1) n_he <= n_he + 1;
   end
   ////////////////////////////////////////////////////////////////
   task print_verdict;
      $display("checks %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [2:0] a, output logic [15:0] d);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task rchk(input logic [2:0] a, input logic [15:0] exp);
      rd(a, rv);
      chk(rv, exp);
   endtask
   task wait_stop;
      int i;
      for (i = 0; i < 600; i++) begin
         rd(REG_STATUS, rv);
         if (rv[1:0] === 2'b00) break;
      end
      if (i == 600) begin
         chk(rv, 16'h0000);
         mismatches++;
         print_verdict;
      end
   endtask
   function automatic logic [7:0] pat(input logic [23:0] a);
      return a[7:0] ^ 8'h5a;
   endfunction
   // descriptors live in the 0x12 page; words stored low byte first
   task desc(input logic [15:0] a, input logic [15:0] link, input logic [23:0] bp, input logic [15:0] len,
             input logic [7:0] fl);
      logic [79:0] img;
      img = {8'h00, fl, len, 8'h00, bp, link};
      for (int i = 0; i < 10; i++) u_txdma_mem_model.mem[{8'h12, a} + i] = img[8*i +: 8];
   endtask
   task unit(input logic [23:0] a, input logic w, input logic fe);
      exp_q.push_back({fe, w, w ? {pat(a + 24'h1), pat(a)} : {8'h00, pat(a)}});
   endtask
   task cmp_stream;
      chk(got_q.size(), exp_q.size());
      while (got_q.size() > 0 && exp_q.size() > 0) chk(got_q.pop_front(), exp_q.pop_front());
      got_q.delete();
      exp_q.delete();
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      #2000000;
      mismatches++;
      print_verdict;
   end
   initial begin
      repeat (6) @(posedge clock);
      rstn <= 1'b1;
      for (int i = 0; i < 8; i++) rchk(i[2:0], 16'h0000);
      $display("test reset values done");
      desc(16'h0100, 16'h0110, 24'h340001, 16'h0005, 8'h00);
      desc(16'h0110, 16'h0120, 24'h340010, 16'h0002, 8'h80);
      desc(16'h0120, 16'h0130, 24'h340020, 16'h0003, 8'hc0);
      wr(REG_CHAIN_BASE, 16'h0012);
      wr(REG_HALT_PTR, 16'h0130);
      wr(REG_CUR_PTR, 16'h0100);
      wr(REG_CONFIG, 16'h001d);
      slow <= 1'b1;
      req_mode <= 1;
      m0 = n_mrd;
      f0 = n_fd;
      wr(REG_STATUS, 16'h0002);
      repeat (20) @(posedge clock);
      chk(n_mrd - m0, 0);
      rchk(REG_STATUS, 16'h0003);
      chk(bus_req, 1'b1);
      bus_grant <= 1'b1;
      wait_stop;
      chk(first_addr, 24'h120100);
      unit(24'h340001, 0, 0);
      unit(24'h340002, 1, 0);
      unit(24'h340004, 1, 0);
      unit(24'h340010, 1, 1);
      cmp_stream;
      rchk(REG_CUR_PTR, 16'h0120);
      rchk(REG_REMAIN, 16'h0000);
      rchk(REG_BUF_LO, 16'h0012);
      rchk(REG_BUF_HI, 16'h0034);
      chk(n_fd - f0, 1);
      $display("test single frame done");
      wr(REG_STATUS, 16'h0002);
      wait_stop;
      unit(24'h340020, 1, 0);
      unit(24'h340022, 0, 1);
      cmp_stream;
      rchk(REG_CUR_PTR, 16'h0130);
      chk(n_fd - f0, 2);
      $display("test second frame done");
      m0 = n_mrd;
      h0 = n_he;
      wr(REG_STATUS, 16'h0002);
      wait_stop;
      chk(n_mrd - m0, 0);
      chk(n_he - h0, 1);
      rchk(REG_CUR_PTR, 16'h0130);
      chk(bus_req, 1'b0);
      $display("test halt match done");
      // halt pointer parked on the second entry, then moved on while running
      wr(REG_CUR_PTR, 16'h0100);
      wr(REG_HALT_PTR, 16'h0110);
      wr(REG_CONFIG, 16'h001f);
      req_mode <= 0;
      slow <= 1'b0;
      f0 = n_fd;
      wr(REG_STATUS, 16'h0002);
      repeat (10) @(posedge clock);
      wr(REG_HALT_PTR, 16'h0130);
      req_mode <= 2;
      wait_stop;
      unit(24'h340001, 0, 0);
      unit(24'h340002, 1, 0);
      unit(24'h340004, 1, 0);
      unit(24'h340010, 1, 1);
      unit(24'h340020, 1, 0);
      unit(24'h340022, 0, 1);
      cmp_stream;
      chk(n_he - h0, 1);
      chk(n_fd - f0, 2);
      rchk(REG_CUR_PTR, 16'h0130);
      rchk(REG_STATUS, 16'h0020);
      $display("test multi frame done");
      // two frames still pending from the multi run; acknowledge both first
      wr(REG_STATUS, 16'h0004);
      wr(REG_STATUS, 16'h0004);
      rchk(REG_STATUS, 16'h0000);
      for (int i = 0; i < 20; i++) desc(16'h0200 + 16'(i * 16), 16'h0210 + 16'(i * 16), 24'h350000 + 24'(i),
                                      16'h0002, 8'h80);
      wr(REG_CUR_PTR, 16'h0200);
      wr(REG_HALT_PTR, 16'h0400);
      wr(REG_CONFIG, 16'h001b);
      req_mode <= 1;
      f0 = n_fd;
      wr(REG_STATUS, 16'h0002);
      wait_stop;
      // 8-bit bus: every buffer goes out as two single bytes
      for (int i = 0; i < 16; i++) begin
         unit(24'h350000 + 24'(i), 0, 0);
         unit(24'h350001 + 24'(i), 0, 1);
      end
      cmp_stream;
      chk(n_fd - f0, 16);
      chk(n_he - h0, 2);
      rd(REG_STATUS, rv);
      chk(rv[7:4], 4'h0);
      rchk(REG_CUR_PTR, 16'h0300);
      $display("test frame counter overflow done");
      print_verdict;
   end
endmodule
